/* File: gpio_port_pkg.sv */
// gpio port package: register offsets, widths, reset values, bus carrier types
// assumes a 32-bit apb slave with word-aligned byte offsets
package gpio_port_pkg;

  localparam int unsigned          PIN_COUNT      = 12;
  localparam int unsigned          ADDR_WIDTH     = 12;
  localparam int unsigned          DATA_WIDTH     = 32;

  // register byte offsets
  localparam logic [11:0]          OFS_DATA       = 12'h000;
  localparam logic [11:0]          OFS_DIRECTION  = 12'h004;
  localparam logic [11:0]          OFS_SENSE      = 12'h00c;
  localparam logic [11:0]          OFS_DUAL_EDGE  = 12'h010;
  localparam logic [11:0]          OFS_POLARITY   = 12'h014;
  localparam logic [11:0]          OFS_IRQ_EN     = 12'h018;
  localparam logic [11:0]          OFS_RAW_FLAGS  = 12'h01c;
  localparam logic [11:0]          OFS_FLAG_CLEAR = 12'h020;
  localparam logic [11:0]          OFS_BIT_SET    = 12'h024;
  localparam logic [11:0]          OFS_BIT_CLEAR  = 12'h028;
  localparam logic [11:0]          OFS_OPEN_DRAIN = 12'h02c;
  localparam logic [11:0]          OFS_IRQ_STATUS = 12'h030;
  localparam logic [11:0]          OFS_IRQ_MASK   = 12'h034;

  // reset values and implemented open-drain bits per port
  localparam logic [11:0]          PIN_RESET      = 12'h000;
  localparam logic [11:0]          OD_MASK_PORT0  = 12'h03f;
  localparam logic [11:0]          OD_MASK_PORT1  = 12'h0c0;
  localparam logic [11:0]          OD_MASK_NONE   = 12'h000;

  // sticky event bits of the status register
  localparam int unsigned          EV_PIN_IRQ     = 0;
  localparam int unsigned          EV_BAD_ADDR    = 1;
  localparam int unsigned          EV_COUNT       = 2;
  localparam logic [EV_COUNT-1:0]  EV_RESET       = 2'h0;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [ADDR_WIDTH-1:0] paddr;
    logic [DATA_WIDTH-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic                  pready;
    logic                  pslverr;
    logic [DATA_WIDTH-1:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic [PIN_COUNT-1:0] pin_out;
    logic [PIN_COUNT-1:0] pin_oe;
  } pin_drive_t;

endpackage

/* File: gpio_port.sv */
// gpio port: data, direction, pin interrupts, atomic bit ops, open drain
// assumes apb master on mclk; pins arrive asynchronously and are synchronised here
//
// Contract
// - sense-type bit 0 selects edge detection, 1 selects level detection
// - dual-edge bit 1 triggers on every rising and every falling transition
// - dual-edge bit 0 lets the polarity bit choose direction or level
// - polarity 0: rising edge in edge mode, high level in level mode
// - polarity 1: falling edge in edge mode, low level in level mode
// - enable bit 1 lets a pin interrupt, 0 stops it
// - raw flag is read-only, set when trigger condition met, resets to zero
// - request forwarded only when raw flag and enable are both set
// - flag-clear write clears flags where written one, others untouched
// - bit-set write sets output bits written one, others untouched
// - bit-clear write clears output bits written one, others untouched
// - port 1: open-drain bits 7 and 6 enable open drain and force output
// - port 0: open-drain bits 5 to 0 enable open drain and force output
// - open-drain pin drives only low and releases for high; pull-up outside
// - data register reads synchronised pins and writes output values
// - direction bit 1 makes the pin an output, 0 an input
//
// Our own choice: the APB register port.
`timescale 1ns/100ps

module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int unsigned PORT_INDEX = 0
)
(
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  // apb slave
  input  wire apb_req_t             apb_req,
  output      apb_rsp_t             apb_rsp,
  // pins
  input  wire logic [PIN_COUNT-1:0] pin_in,
  output      pin_drive_t           pin_drive,
  // interrupts
  output      logic [PIN_COUNT-1:0] pin_irq,
  output      logic                 irq
);

  localparam logic [PIN_COUNT-1:0] OD_MASK =
    (PORT_INDEX == 0) ? OD_MASK_PORT0 : (PORT_INDEX == 1) ? OD_MASK_PORT1 : OD_MASK_NONE;

  function automatic logic [DATA_WIDTH-1:0] zext(input logic [PIN_COUNT-1:0] v);
    zext = {{(DATA_WIDTH-PIN_COUNT){1'b0}}, v};
  endfunction

  function automatic logic hit(input logic [ADDR_WIDTH-1:0] a, input logic [ADDR_WIDTH-1:0] o);
    hit = (a == o);
  endfunction

  logic                 rst_meta_q;
  logic                 rst_sync_q;
  logic                 rst_n;
  logic [PIN_COUNT-1:0] pin_meta_q;
  logic [PIN_COUNT-1:0] pin_sync_q;
  logic [PIN_COUNT-1:0] pin_prev_q;
  logic [PIN_COUNT-1:0] out_data_q;
  logic [PIN_COUNT-1:0] direction_q;
  logic [PIN_COUNT-1:0] sense_type_bits_q;
  logic [PIN_COUNT-1:0] dual_edge_bits_q;
  logic [PIN_COUNT-1:0] polarity_bits_q;
  logic [PIN_COUNT-1:0] pin_irq_enable_bits_q;
  logic [PIN_COUNT-1:0] raw_flag_q;
  logic [PIN_COUNT-1:0] open_drain_q;
  logic [EV_COUNT-1:0]  ev_status_q;
  logic [EV_COUNT-1:0]  ev_mask_q;
  logic [DATA_WIDTH-1:0] prdata_q;

  // reset release through two flops
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // bus decode
  wire                  access_phase = apb_req.psel & apb_req.penable;
  wire                  wr_en        = access_phase & apb_req.pwrite;
  wire                  rd_en        = access_phase & ~apb_req.pwrite;
  wire [ADDR_WIDTH-1:0] addr         = apb_req.paddr;
  wire [PIN_COUNT-1:0]  wdata        = apb_req.pwdata[PIN_COUNT-1:0];
  wire wr_data       = wr_en & hit(addr, OFS_DATA);
  wire wr_direction  = wr_en & hit(addr, OFS_DIRECTION);
  wire wr_sense      = wr_en & hit(addr, OFS_SENSE);
  wire wr_dual_edge  = wr_en & hit(addr, OFS_DUAL_EDGE);
  wire wr_polarity   = wr_en & hit(addr, OFS_POLARITY);
  wire wr_irq_en     = wr_en & hit(addr, OFS_IRQ_EN);
  wire wr_flag_clear = wr_en & hit(addr, OFS_FLAG_CLEAR);
  wire wr_bit_set    = wr_en & hit(addr, OFS_BIT_SET);
  wire wr_bit_clear  = wr_en & hit(addr, OFS_BIT_CLEAR);
  wire wr_open_drain = wr_en & hit(addr, OFS_OPEN_DRAIN);
  wire wr_irq_mask   = wr_en & hit(addr, OFS_IRQ_MASK);
  wire rd_irq_status = rd_en & hit(addr, OFS_IRQ_STATUS);
  wire addr_known    = hit(addr, OFS_DATA) | hit(addr, OFS_DIRECTION) | hit(addr, OFS_SENSE)
                     | hit(addr, OFS_DUAL_EDGE) | hit(addr, OFS_POLARITY)
                     | hit(addr, OFS_IRQ_EN) | hit(addr, OFS_RAW_FLAGS)
                     | hit(addr, OFS_FLAG_CLEAR) | hit(addr, OFS_BIT_SET)
                     | hit(addr, OFS_BIT_CLEAR) | hit(addr, OFS_OPEN_DRAIN)
                     | hit(addr, OFS_IRQ_STATUS) | hit(addr, OFS_IRQ_MASK);
  wire bad_access    = access_phase & ~addr_known;

  // pin synchroniser and previous sample
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_q <= PIN_RESET;
      pin_sync_q <= PIN_RESET;
      pin_prev_q <= PIN_RESET;
    end
    else
    begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  // trigger detection
  wire [PIN_COUNT-1:0] rise_edge  = pin_sync_q & ~pin_prev_q;
  wire [PIN_COUNT-1:0] fall_edge  = ~pin_sync_q & pin_prev_q;
  wire [PIN_COUNT-1:0] edge_dir   = polarity_bits_q & fall_edge
                                  | ~polarity_bits_q & rise_edge;
  wire [PIN_COUNT-1:0] edge_hit   = dual_edge_bits_q & (rise_edge | fall_edge)
                                  | ~dual_edge_bits_q & edge_dir;
  wire [PIN_COUNT-1:0] level_hit  = polarity_bits_q & ~pin_sync_q
                                  | ~polarity_bits_q & pin_sync_q;
  wire [PIN_COUNT-1:0] trig       = (sense_type_bits_q & level_hit
                                  | ~sense_type_bits_q & edge_hit)
                                  & pin_irq_enable_bits_q;
  wire [PIN_COUNT-1:0] flag_clr   = wr_flag_clear ? wdata : PIN_RESET;
  wire [PIN_COUNT-1:0] raw_flag_d = trig | (raw_flag_q & ~flag_clr);

  // output data: plain write, atomic set and clear
  wire [PIN_COUNT-1:0] set_bits   = wr_bit_set ? wdata : PIN_RESET;
  wire [PIN_COUNT-1:0] clr_bits   = wr_bit_clear ? wdata : PIN_RESET;
  wire [PIN_COUNT-1:0] out_data_d = ((wr_data ? wdata : out_data_q) | set_bits) & ~clr_bits;

  // interrupt events: set wins over read-clear
  wire [EV_COUNT-1:0]  ev_set     = {bad_access, |(raw_flag_q & pin_irq_enable_bits_q)};
  wire [EV_COUNT-1:0]  ev_status_d = ev_set | (rd_irq_status ? EV_RESET : ev_status_q);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_data_q            <= PIN_RESET;
      direction_q           <= PIN_RESET;
      sense_type_bits_q     <= PIN_RESET;
      dual_edge_bits_q      <= PIN_RESET;
      polarity_bits_q       <= PIN_RESET;
      pin_irq_enable_bits_q <= PIN_RESET;
      raw_flag_q            <= PIN_RESET;
      open_drain_q          <= PIN_RESET;
      ev_status_q           <= EV_RESET;
      ev_mask_q             <= EV_RESET;
    end
    else
    begin
      out_data_q            <= out_data_d;
      direction_q           <= wr_direction ? wdata : direction_q;
      sense_type_bits_q     <= wr_sense ? wdata : sense_type_bits_q;
      dual_edge_bits_q      <= wr_dual_edge ? wdata : dual_edge_bits_q;
      polarity_bits_q       <= wr_polarity ? wdata : polarity_bits_q;
      pin_irq_enable_bits_q <= wr_irq_en ? wdata : pin_irq_enable_bits_q;
      raw_flag_q            <= raw_flag_d;
      open_drain_q          <= wr_open_drain ? (wdata & OD_MASK) : open_drain_q;
      ev_status_q           <= ev_status_d;
      ev_mask_q             <= wr_irq_mask ? apb_req.pwdata[EV_COUNT-1:0] : ev_mask_q;
    end
  end

  // read mux; unmapped reads give zero
  logic [DATA_WIDTH-1:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    case (addr)
      OFS_DATA:       rd_mux = zext(pin_sync_q);
      OFS_DIRECTION:  rd_mux = zext(direction_q);
      OFS_SENSE:      rd_mux = zext(sense_type_bits_q);
      OFS_DUAL_EDGE:  rd_mux = zext(dual_edge_bits_q);
      OFS_POLARITY:   rd_mux = zext(polarity_bits_q);
      OFS_IRQ_EN:     rd_mux = zext(pin_irq_enable_bits_q);
      OFS_RAW_FLAGS:  rd_mux = zext(raw_flag_q);
      OFS_OPEN_DRAIN: rd_mux = zext(open_drain_q);
      OFS_IRQ_STATUS: rd_mux = {{(DATA_WIDTH-EV_COUNT){1'b0}}, ev_status_q};
      OFS_IRQ_MASK:   rd_mux = {{(DATA_WIDTH-EV_COUNT){1'b0}}, ev_mask_q};
      default:        rd_mux = '0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      prdata_q <= '0;
    else if (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite)
      prdata_q <= rd_mux;
  end

  // zero-wait slave; read data captured in the setup cycle
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = bad_access;
  assign apb_rsp.prdata  = prdata_q;

  // pin drivers: open-drain pins forced to output, drive low only
  wire [PIN_COUNT-1:0] pin_is_out = direction_q | open_drain_q;
  assign pin_drive.pin_out = out_data_q & ~open_drain_q;
  assign pin_drive.pin_oe  = pin_is_out & ~(open_drain_q & out_data_q);

  assign pin_irq = raw_flag_q & pin_irq_enable_bits_q;
  assign irq     = |(ev_status_q & ev_mask_q);

  // assertions
  sequence s_rise_seen(int unsigned i);
    !pin_prev_q[i] && pin_sync_q[i];
  endsequence

  property p_edge_flag;
    @(posedge mclk) disable iff (!rst_n)
    (|(rise_edge & ~sense_type_bits_q & ~dual_edge_bits_q & ~polarity_bits_q
       & pin_irq_enable_bits_q)) |=> (|raw_flag_q);
  endproperty

  a_rise_sets_flag: assert property (p_edge_flag)
    else $error("rising edge did not set flag");

  a_dual_edge_fall: assert property (@(posedge mclk) disable iff (!rst_n)
    (fall_edge[0] && dual_edge_bits_q[0] && !sense_type_bits_q[0] && pin_irq_enable_bits_q[0])
    |=> raw_flag_q[0])
    else $error("dual edge fall missed");

  a_fall_ignored: assert property (@(posedge mclk) disable iff (!rst_n)
    (fall_edge[0] && !dual_edge_bits_q[0] && !polarity_bits_q[0] && !sense_type_bits_q[0]
     && !raw_flag_q[0] && !wr_irq_en) |=> !raw_flag_q[0])
    else $error("falling edge set flag under rising polarity");

  a_level_low: assert property (@(posedge mclk) disable iff (!rst_n)
    (sense_type_bits_q[0] && polarity_bits_q[0] && !pin_sync_q[0] && pin_irq_enable_bits_q[0])
    |=> raw_flag_q[0])
    else $error("low level did not hold flag");

  a_disabled_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    (!pin_irq_enable_bits_q[0] && !raw_flag_q[0]) |=> !raw_flag_q[0])
    else $error("disabled pin raised flag");

  a_irq_forward: assert property (@(posedge mclk) disable iff (!rst_n)
    pin_irq == (raw_flag_q & pin_irq_enable_bits_q))
    else $error("pin request mismatch");

  a_flag_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_flag_clear && wdata[0] && !trig[0]) |=> !raw_flag_q[0])
    else $error("flag clear failed");

  a_bit_set: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_bit_set && wdata[8] && !wdata[0]) |=> out_data_q[8] && $stable(out_data_q[0]))
    else $error("bit set wrong");

  a_bit_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_bit_clear && wdata[0] && !wdata[1]) |=> !out_data_q[0] && $stable(out_data_q[1]))
    else $error("bit clear wrong");

  // a high data bit on an open-drain pin must release the pad
  a_od_no_high: assert property (@(posedge mclk) disable iff (!rst_n)
    (pin_drive.pin_oe & open_drain_q & out_data_q) == PIN_RESET)
    else $error("open drain drove high");

  a_od_reserved: assert property (@(posedge mclk) disable iff (!rst_n)
    (open_drain_q & ~OD_MASK) == PIN_RESET)
    else $error("unimplemented open drain bit set");

  a_rise_reaches: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_rise_seen(0) && !sense_type_bits_q[0] && !polarity_bits_q[0]
     && pin_irq_enable_bits_q[0] && !wr_flag_clear && !wr_irq_en && !wr_polarity
     && !wr_sense) ##1 1'b1 |-> ##[0:1] pin_irq[0])
    else $error("edge did not reach request");

  sequence s_fall_seen(int unsigned i);
    pin_prev_q[i] && !pin_sync_q[i];
  endsequence

  property p_dual_rise;
    @(posedge mclk) disable iff (!rst_n)
    (s_rise_seen(1) ##0 (dual_edge_bits_q[1] && !sense_type_bits_q[1]
     && pin_irq_enable_bits_q[1])) |=> raw_flag_q[1];
  endproperty

  a_dual_edge_rise: assert property (p_dual_rise)
    else $error("dual edge rise missed");

  property p_fall_flag;
    @(posedge mclk) disable iff (!rst_n)
    (s_fall_seen(0) ##0 (!sense_type_bits_q[0] && !dual_edge_bits_q[0]
     && polarity_bits_q[0] && pin_irq_enable_bits_q[0])) |=> raw_flag_q[0];
  endproperty

  a_fall_sets_flag: assert property (p_fall_flag)
    else $error("falling edge did not set flag");

  property p_level_high;
    @(posedge mclk) disable iff (!rst_n)
    (sense_type_bits_q[1] && !polarity_bits_q[1] && pin_sync_q[1]
     && pin_irq_enable_bits_q[1]) |=> raw_flag_q[1];
  endproperty

  a_level_high: assert property (p_level_high)
    else $error("high level did not hold flag");

  // in edge mode a steady pin must never raise a flag
  property p_edge_quiet;
    @(posedge mclk) disable iff (!rst_n)
    (!sense_type_bits_q[0] && !rise_edge[0] && !fall_edge[0] && !raw_flag_q[0])
    |=> !raw_flag_q[0];
  endproperty

  a_edge_steady_quiet: assert property (p_edge_quiet)
    else $error("steady pin raised edge flag");

  property p_data_write;
    @(posedge mclk) disable iff (!rst_n)
    wr_data |=> (out_data_q == $past(wdata));
  endproperty

  a_data_write: assert property (p_data_write)
    else $error("data write not loaded");

  property p_dir_write;
    @(posedge mclk) disable iff (!rst_n)
    wr_direction |=> (direction_q == $past(wdata));
  endproperty

  a_dir_write: assert property (p_dir_write)
    else $error("direction write not loaded");

  property p_od_forces_out;
    @(posedge mclk) disable iff (!rst_n)
    (open_drain_q & ~out_data_q & ~pin_drive.pin_oe) == PIN_RESET;
  endproperty

  a_od_drives_low: assert property (p_od_forces_out)
    else $error("open drain low not driven");

  property p_reserved_zero;
    @(posedge mclk) disable iff (!rst_n)
    rd_en |-> (apb_rsp.prdata[DATA_WIDTH-1:PIN_COUNT] == '0);
  endproperty

  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved read bits not zero");

  property p_raw_readonly;
    @(posedge mclk) disable iff (!rst_n)
    (wr_en && hit(addr, OFS_RAW_FLAGS) && trig == PIN_RESET)
    |=> (raw_flag_q == $past(raw_flag_q));
  endproperty

  a_raw_readonly: assert property (p_raw_readonly)
    else $error("raw flags changed by write");

  // a trigger in the cycle of a clear keeps the flag set
  property p_set_wins;
    @(posedge mclk) disable iff (!rst_n)
    (trig[0] && wr_flag_clear && wdata[0]) |=> raw_flag_q[0];
  endproperty

  a_flag_set_wins: assert property (p_set_wins)
    else $error("clear beat a trigger");

endmodule

/* File: gpio_pin_world.sv */
// pad model: resolves each pad from the port drive, an external driver and a pull-up
// assumes at most one external driver per pad and a pull-up on every pad
`timescale 1ns/100ps

module gpio_pin_world
  import gpio_port_pkg::*;
(
  // port side
  input  wire pin_drive_t           drv,
  // external side
  input  wire logic [PIN_COUNT-1:0] ext_en,
  input  wire logic [PIN_COUNT-1:0] ext_val,
  output      logic [PIN_COUNT-1:0] pad
);
  // a pad that nobody drives is pulled high
  assign pad = (drv.pin_oe & drv.pin_out) | (~drv.pin_oe & ext_en & ext_val)
             | (~drv.pin_oe & ~ext_en);
endmodule

/* File: tb_gpio_port_interrupt_and_bit_ops.sv */
// testbench for gpio_port: apb tasks, pin stimulus through the pad model
// assumes gpio_port_pkg and gpio_pin_world are compiled first
`timescale 1ns/100ps

module tb_gpio_port_interrupt_and_bit_ops;
  import gpio_port_pkg::*;

  logic                 mclk;
  logic                 reset_n;
  apb_req_t             req;
  apb_rsp_t             rsp;
  apb_rsp_t             rsp1;
  pin_drive_t           drv;
  pin_drive_t           drv1;
  logic [PIN_COUNT-1:0] pad;
  logic [PIN_COUNT-1:0] ext_en;
  logic [PIN_COUNT-1:0] ext_val;
  logic [PIN_COUNT-1:0] pin_irq;
  logic                 irq;
  logic                 last_err;
  logic [31:0]          rd;
  logic [31:0]          rd1;
  logic [6:0]           mode [10] = '{7'h43, 7'h44, 7'h4d, 7'h4a, 7'h53, 7'h55, 7'h63,
                                      7'h6d, 7'h60, 7'h02};
  int                   n_errors = 0;
  int                   checks = 0;
  int                   cyc = 0;

  gpio_port #(.PORT_INDEX(0)) u_dut (.mclk(mclk), .reset_n(reset_n), .apb_req(req),
    .apb_rsp(rsp), .pin_in(pad), .pin_drive(drv), .pin_irq(pin_irq), .irq(irq));
  gpio_port #(.PORT_INDEX(1)) u_dut1 (.mclk(mclk), .reset_n(reset_n), .apb_req(req),
    .apb_rsp(rsp1), .pin_in(12'h000), .pin_drive(drv1), .pin_irq(), .irq());
  gpio_pin_world u_pads (.drv(drv), .ext_en(ext_en), .ext_val(ext_val), .pad(pad));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; entered right after a rising edge, returns right after one
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge mclk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    rd1 = rsp1.prdata;
    last_err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  initial
  begin
    reset_n = 1'b0;
    req = '0;
    ext_en = 12'h000;
    ext_val = 12'h000;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    tick(3);
    for (int a = 12; a <= 24; a += 4)
    begin
      rdchk(a[11:0], 32'h0);
      wr(a[11:0], 32'hffffffff);
      rdchk(a[11:0], 32'h00000fff);
      wr(a[11:0], 32'h0);
    end
    rdchk(OFS_RAW_FLAGS, 32'h0);
    wr(OFS_RAW_FLAGS, 32'hfff);
    rdchk(OFS_RAW_FLAGS, 32'h0);
    $display("test registers done");
    xfer(1'b0, 12'h03c, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h2);
    tick(1);
    chk({31'h0, irq}, 32'h1);
    rdchk(OFS_IRQ_STATUS, 32'h2);
    tick(1);
    chk({31'h0, irq}, 32'h0);
    rdchk(OFS_IRQ_STATUS, 32'h0);
    $display("test bad address done");
    wr(OFS_DIRECTION, 32'hfff);
    wr(OFS_DATA, 32'h0a5);
    wr(OFS_BIT_SET, 32'h300);
    tick(1);
    chk({20'h0, drv.pin_out}, 32'h3a5);
    wr(OFS_BIT_CLEAR, 32'h005);
    tick(1);
    chk({20'h0, drv.pin_out}, 32'h3a0);
    chk({20'h0, drv.pin_oe}, 32'hfff);
    tick(3);
    rdchk(OFS_DATA, 32'h3a0);
    $display("test bit ops done");
    wr(OFS_DIRECTION, 32'h0);
    wr(OFS_OPEN_DRAIN, 32'hfff);
    rdchk(OFS_OPEN_DRAIN, 32'h03f);
    chk(rd1, 32'h0c0);
    tick(1);
    chk({20'h0, drv.pin_oe}, 32'h01f);
    chk({20'h0, drv.pin_out}, 32'h380);
    chk({20'h0, drv1.pin_oe}, 32'h040);
    tick(3);
    rdchk(OFS_DATA, 32'hfe0);
    wr(OFS_OPEN_DRAIN, 32'h0);
    $display("test open drain done");
    ext_en <= 12'hfff;
    for (int i = 0; i < 10; i++)
    begin
      logic [6:0] m;
      m = mode[i];
      ext_val <= {11'h0, m[2]};
      wr(OFS_SENSE, {31'h0, m[5]});
      wr(OFS_DUAL_EDGE, {31'h0, m[4]});
      wr(OFS_POLARITY, {31'h0, m[3]});
      wr(OFS_IRQ_EN, {31'h0, m[6]});
      tick(4);
      wr(OFS_FLAG_CLEAR, 32'hfff);
      ext_val <= {11'h0, m[1]};
      tick(5);
      rdchk(OFS_RAW_FLAGS, {31'h0, m[0]});
      chk({20'h0, pin_irq}, {31'h0, m[0]});
      wr(OFS_FLAG_CLEAR, 32'hffe);
      rdchk(OFS_RAW_FLAGS, {31'h0, m[0]});
      wr(OFS_FLAG_CLEAR, 32'h001);
      rdchk(OFS_RAW_FLAGS, {31'h0, m[0] & m[5]});
    end
    $display("test pin interrupts done");
    print_verdict();
  end
endmodule
